// ==== hw/awx_exec.sv ====
`include "awx_consts.svh"

// Notes on behaviour
// - indexed call target: low word at reg+index, high at +2, index signed 16
// - clear_address zeroes all 20 destination bits, flags untouched
// - compare_address adds ones' complement of source plus one, flags only
// - compare/subtract: N from result bit 19, Z when source equals destination
// - compare/subtract: C is carry out of destination bit 19
// - subtraction V: operand signs differ and result sign differs from dst
// - subtract_address writes difference to destination, source untouched
// - double_decrement subtracts two; Z if old was two, C clear if below two
// - double_increment adds two; C only if old was 0FFFFE or 0FFFFF
// - double_increment V only if old was 07FFFE or 07FFFF
// - move_address copies all 20 bits, source kept, flags untouched
// - move_address memory operands are two words, low at addr, high at +2
// - move_address auto-increment source bumps pointer by four after read
// - return pops low word to pc 15:0, sp+2, high word to 19:16, sp+2
// - return leaves status_word 11:0 alone
// - test_address: N,Z from value, C always set, V always clear
// - mode bits of status_word change by a wishbone write to R2, a move_address/clear_address into R2, or R2 as auto-increment pointer
// - decd/incd/clr/tst run as sub #2, add #2, mov #0, cmp #0
// - call auto-increment: target from pair at pointer, then pointer += 4
// - call pushes pc 19:16 then 15:0, sp down two each, then pc = target
module awx_exec
  import awx_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // command from fetch/decode
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input awx_op_t cmd_op_i,
  input awx_smode_t cmd_smode_i,
  input awx_dmode_t cmd_dmode_i,
  input wire logic [3:0] cmd_src_i,
  input wire logic [3:0] cmd_dst_i,
  input wire logic [19:0] cmd_imm_i,
  output logic done_o,
  // data memory and stack, 16-bit words
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [19:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic [15:0] mem_rdata_i,
  input wire logic mem_ack_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  awx_state_s_t s_q;
  awx_state_s_t s_d;

  logic [20:0] alu_sum;
  logic [19:0] alu_b;
  logic [19:0] alu_a;
  logic [19:0] new_flags;
  logic wb_wr_now;
  logic [5:0] wb_idx;

  function automatic logic [19:0] sext16(input logic [19:0] v);
    sext16 = {{4{v[15]}}, v[15:0]};
  endfunction

  // wrapping 20-bit add, keeps the carry in bit 20
  function automatic logic [20:0] add20(input logic [19:0] a,
                                        input logic [19:0] b,
                                        input logic cin);
    add20 = {1'b0, a} + {1'b0, b} + {20'h00000, cin};
  endfunction

  function automatic logic [19:0] sp_step(input logic [19:0] sp,
                                          input logic down);
    sp_step = down ? sp - `AWX_WORD_STEP : sp + `AWX_WORD_STEP;
  endfunction

  function automatic logic [19:0] rd_mux(input awx_state_s_t s,
                                         input logic [5:0] idx);
    logic [19:0] v;
    v = `AWX_RST_WORD20;
    if (idx <= `AWX_WB_REG_LAST)
    begin
      v = s.rf[idx[3:0]];
    end
    rd_mux = v;
  endfunction

  assign alu_a = s_q.rf[s_q.dst];
  // subtraction is addition of the ones' complement plus one
  assign alu_b = (s_q.op == AWX_OP_ADD) ? s_q.tmp : ~s_q.tmp;
  assign alu_sum = add20(alu_a, alu_b, s_q.op != AWX_OP_ADD);

  // flags for add, subtract and compare; decd, incd and tst inherit these, clr does not
  always_comb
  begin
    new_flags = s_q.rf[`AWX_SR_IDX];
    new_flags[`AWX_SR_N] = alu_sum[19];
    new_flags[`AWX_SR_Z] = (alu_sum[19:0] == `AWX_RST_WORD20);
    new_flags[`AWX_SR_C] = alu_sum[20];
    new_flags[`AWX_SR_V] = (alu_a[19] == alu_b[19]) &&
                           (alu_sum[19] != alu_a[19]);
  end

  assign wb_idx = wb_adr_i[7:2];
  assign wb_wr_now = s_q.wb_ack && wb_cyc_i && wb_stb_i && wb_we_i;
  // a register write from software takes the idle cycle over a command
  assign cmd_ready_o = (s_q.st == AWX_ST_IDLE) && !wb_wr_now;

  always_comb
  begin
    logic [19:0] ea;
    logic [19:0] sp;
    logic [19:0] wv;
    ea = `AWX_RST_WORD20;
    sp = s_q.rf[`AWX_SP_IDX];
    wv = `AWX_RST_WORD20;
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.wb_ack = 1'b0;

    // bus slave: read data taken on the request cycle, ack one cycle later; writes land in the ack cycle
    if (wb_cyc_i && wb_stb_i && !s_q.wb_ack)
    begin
      s_d.wb_ack = 1'b1;
      s_d.wb_dat = `AWX_RST_DATA32;
      if (wb_idx == `AWX_WB_STATUS)
      begin
        s_d.wb_dat[`AWX_WB_BUSY_BIT] = (s_q.st != AWX_ST_IDLE);
        s_d.wb_dat[`AWX_WB_FLAG_LSB +: 20] =
          s_q.rf[`AWX_SR_IDX] & `AWX_SR_FLAGS;
      end
      else
      begin
        s_d.wb_dat[19:0] = rd_mux(s_q, wb_idx);
      end
    end
    // writes land only while idle; busy writes are dropped
    if (wb_wr_now && s_q.st == AWX_ST_IDLE && wb_idx <= `AWX_WB_REG_LAST)
    begin
      wv = s_q.rf[wb_idx[3:0]];
      if (wb_sel_i[0])
      begin
        wv[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1])
      begin
        wv[15:8] = wb_dat_i[15:8];
      end
      if (wb_sel_i[2])
      begin
        wv[19:16] = wb_dat_i[19:16];
      end
      s_d.rf[wb_idx[3:0]] = wv;
    end

    case (s_q.st)
      AWX_ST_IDLE:
      begin
        if (cmd_valid_i && cmd_ready_o)
        begin
          s_d.op = cmd_op_i;
          s_d.smode = cmd_smode_i;
          s_d.dmode = cmd_dmode_i;
          s_d.src = cmd_src_i;
          s_d.dst = cmd_dst_i;
          s_d.imm = cmd_imm_i;
          case (cmd_op_i)
            AWX_OP_DECD:
            begin
              s_d.op = AWX_OP_SUB;
              s_d.smode = AWX_SM_IMM;
              s_d.imm = `AWX_IMM_TWO;
            end
            AWX_OP_INCD:
            begin
              s_d.op = AWX_OP_ADD;
              s_d.smode = AWX_SM_IMM;
              s_d.imm = `AWX_IMM_TWO;
            end
            AWX_OP_CLR:
            begin
              s_d.op = AWX_OP_MOV;
              s_d.smode = AWX_SM_IMM;
              s_d.dmode = AWX_DM_REG;
              s_d.imm = `AWX_IMM_ZERO;
            end
            AWX_OP_TST:
            begin
              s_d.op = AWX_OP_CMP;
              s_d.smode = AWX_SM_IMM;
              s_d.imm = `AWX_IMM_ZERO;
            end
            default:
            begin
            end
          endcase
          case (s_d.smode)
            AWX_SM_IDX: ea = s_q.rf[cmd_src_i] + sext16(cmd_imm_i);
            AWX_SM_ABS: ea = cmd_imm_i;
            default: ea = s_q.rf[cmd_src_i];
          endcase
          if (cmd_op_i == AWX_OP_RET)
          begin
            s_d.mem_req = 1'b1;
            s_d.mem_we = 1'b0;
            s_d.mem_addr = sp;
            s_d.st = AWX_ST_POP_LO;
          end
          else if (s_d.smode == AWX_SM_REG || s_d.smode == AWX_SM_IMM)
          begin
            s_d.tmp = (s_d.smode == AWX_SM_IMM) ? s_d.imm :
                      s_q.rf[cmd_src_i];
            s_d.st = AWX_ST_EXEC;
          end
          else
          begin
            s_d.mem_req = 1'b1;
            s_d.mem_we = 1'b0;
            s_d.mem_addr = ea;
            s_d.st = AWX_ST_RD_LO;
          end
        end
      end
      AWX_ST_RD_LO:
      begin
        if (mem_ack_i)
        begin
          s_d.tmp[15:0] = mem_rdata_i;
          s_d.mem_addr = s_q.mem_addr + `AWX_WORD_STEP;
          s_d.st = AWX_ST_RD_HI;
        end
      end
      AWX_ST_RD_HI:
      begin
        if (mem_ack_i)
        begin
          s_d.tmp[19:16] = mem_rdata_i[3:0];
          s_d.mem_req = 1'b0;
          if (s_q.smode == AWX_SM_INDINC)
          begin
            // pointer moves only after both words are in
            s_d.rf[s_q.src] = s_q.rf[s_q.src] + `AWX_PAIR_STEP;
          end
          s_d.st = AWX_ST_EXEC;
        end
      end
      AWX_ST_EXEC:
      begin
        s_d.st = AWX_ST_IDLE;
        s_d.done = 1'b1;
        case (s_q.op)
          AWX_OP_ADD, AWX_OP_SUB:
          begin
            s_d.rf[s_q.dst] = alu_sum[19:0];
            s_d.rf[`AWX_SR_IDX] = new_flags;
          end
          AWX_OP_CMP:
          begin
            s_d.rf[`AWX_SR_IDX] = new_flags;
          end
          AWX_OP_MOV:
          begin
            if (s_q.dmode == AWX_DM_REG)
            begin
              s_d.rf[s_q.dst] = s_q.tmp;
            end
            else
            begin
              s_d.done = 1'b0;
              s_d.mem_req = 1'b1;
              s_d.mem_we = 1'b1;
              s_d.mem_addr = (s_q.dmode == AWX_DM_ABS) ? s_q.imm :
                             s_q.rf[s_q.dst] + sext16(s_q.imm);
              s_d.mem_wdata = s_q.tmp[15:0];
              s_d.st = AWX_ST_WR_LO;
            end
          end
          AWX_OP_CALL:
          begin
            s_d.done = 1'b0;
            sp = sp_step(sp, 1'b1);
            s_d.rf[`AWX_SP_IDX] = sp;
            s_d.mem_req = 1'b1;
            s_d.mem_we = 1'b1;
            s_d.mem_addr = sp;
            s_d.mem_wdata = {12'h000, s_q.rf[`AWX_PC_IDX][19:16]};
            s_d.st = AWX_ST_PUSH_HI;
          end
          default:
          begin
          end
        endcase
      end
      AWX_ST_WR_LO:
      begin
        if (mem_ack_i)
        begin
          s_d.mem_addr = s_q.mem_addr + `AWX_WORD_STEP;
          s_d.mem_wdata = {12'h000, s_q.tmp[19:16]};
          s_d.st = AWX_ST_WR_HI;
        end
      end
      AWX_ST_WR_HI, AWX_ST_PUSH_LO:
      begin
        if (mem_ack_i)
        begin
          s_d.mem_req = 1'b0;
          s_d.mem_we = 1'b0;
          s_d.done = 1'b1;
          s_d.st = AWX_ST_IDLE;
          if (s_q.st == AWX_ST_PUSH_LO)
          begin
            s_d.rf[`AWX_PC_IDX] = s_q.tmp;
          end
        end
      end
      AWX_ST_PUSH_HI:
      begin
        if (mem_ack_i)
        begin
          sp = sp_step(sp, 1'b1);
          s_d.rf[`AWX_SP_IDX] = sp;
          s_d.mem_addr = sp;
          s_d.mem_wdata = s_q.rf[`AWX_PC_IDX][15:0];
          s_d.st = AWX_ST_PUSH_LO;
        end
      end
      AWX_ST_POP_LO:
      begin
        if (mem_ack_i)
        begin
          s_d.tmp[15:0] = mem_rdata_i;
          sp = sp_step(sp, 1'b0);
          s_d.rf[`AWX_SP_IDX] = sp;
          s_d.mem_addr = sp;
          s_d.st = AWX_ST_POP_HI;
        end
      end
      AWX_ST_POP_HI:
      begin
        if (mem_ack_i)
        begin
          // status_word is not touched on the return path
          s_d.rf[`AWX_PC_IDX] = {mem_rdata_i[3:0], s_q.tmp[15:0]};
          s_d.rf[`AWX_SP_IDX] = sp_step(sp, 1'b0);
          s_d.mem_req = 1'b0;
          s_d.done = 1'b1;
          s_d.st = AWX_ST_IDLE;
        end
      end
      default:
      begin
        s_d.st = AWX_ST_IDLE;
        s_d.mem_req = 1'b0;
        s_d.mem_we = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.st <= AWX_ST_IDLE;
    end
    else if (ce_i)
    begin
      s_q <= s_d;
    end
  end

  assign done_o = s_q.done;
  assign mem_req_o = s_q.mem_req;
  assign mem_we_o = s_q.mem_we;
  assign mem_addr_o = s_q.mem_addr;
  assign mem_wdata_o = s_q.mem_wdata;
  assign wb_dat_o = s_q.wb_dat;
  assign wb_ack_o = s_q.wb_ack;

endmodule // awx_exec

// ==== shared/awx_consts.svh ====
`ifndef AWX_CONSTS_SVH
`define AWX_CONSTS_SVH

// register file indices with a fixed role
`define AWX_PC_IDX 4'h0
`define AWX_SP_IDX 4'h1
`define AWX_SR_IDX 4'h2

// status_word bit positions
`define AWX_SR_C 0
`define AWX_SR_Z 1
`define AWX_SR_N 2
`define AWX_SR_V 8
`define AWX_SR_FLAGS 20'h00107

// address-word steps and emulation immediates
`define AWX_WORD_STEP 20'h00002
`define AWX_PAIR_STEP 20'h00004
`define AWX_IMM_TWO 20'h00002
`define AWX_IMM_ZERO 20'h00000

// wishbone map: R0..R15 at word index 0..15, status at index 16
`define AWX_WB_REG_LAST 6'h0F
`define AWX_WB_STATUS 6'h10
`define AWX_WB_BUSY_BIT 0
`define AWX_WB_FLAG_LSB 4

// reset values
`define AWX_RST_WORD20 20'h00000
`define AWX_RST_DATA32 32'h00000000

`endif

// ==== shared/awx_pkg.sv ====
package awx_pkg;

  typedef enum logic [3:0] {
    AWX_OP_CALL, AWX_OP_CLR, AWX_OP_CMP, AWX_OP_SUB, AWX_OP_ADD,
    AWX_OP_DECD, AWX_OP_INCD, AWX_OP_TST, AWX_OP_MOV, AWX_OP_RET
  } awx_op_t;

  // source operand modes
  typedef enum logic [2:0] {
    AWX_SM_REG, AWX_SM_IMM, AWX_SM_IDX, AWX_SM_IND, AWX_SM_INDINC,
    AWX_SM_ABS
  } awx_smode_t;

  // destination modes (memory forms only for move_address)
  typedef enum logic [1:0] {
    AWX_DM_REG, AWX_DM_IDX, AWX_DM_ABS
  } awx_dmode_t;

  typedef enum logic [3:0] {
    AWX_ST_IDLE, AWX_ST_RD_LO, AWX_ST_RD_HI, AWX_ST_EXEC, AWX_ST_WR_LO,
    AWX_ST_WR_HI, AWX_ST_PUSH_HI, AWX_ST_PUSH_LO, AWX_ST_POP_LO,
    AWX_ST_POP_HI
  } awx_state_t;

  typedef struct packed {
    awx_state_t st;
    awx_op_t op;
    awx_smode_t smode;
    awx_dmode_t dmode;
    logic [3:0] src;
    logic [3:0] dst;
    logic [19:0] imm;
    logic [19:0] tmp;
    logic [15:0][19:0] rf;
    logic mem_req;
    logic mem_we;
    logic [19:0] mem_addr;
    logic [15:0] mem_wdata;
    logic done;
    logic wb_ack;
    logic [31:0] wb_dat;
  } awx_state_s_t;

endpackage

// ==== tb/awx_exec_props.sv ====
module awx_exec_props
  import awx_pkg::*;
(
  // clock and command
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input awx_op_t cmd_op_i,
  input awx_smode_t cmd_smode_i,
  input awx_dmode_t cmd_dmode_i,
  input wire logic [3:0] cmd_src_i,
  input wire logic [3:0] cmd_dst_i,
  input wire logic [19:0] cmd_imm_i,
  input wire logic done_o,
  // memory
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [19:0] mem_addr_o,
  input wire logic [15:0] mem_wdata_o,
  input wire logic [15:0] mem_rdata_i,
  input wire logic mem_ack_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic take;
  assign take = cmd_valid_i && cmd_ready_o && ce_i;

  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i
    |=> wb_ack_o) else $error("ack not in next cycle");
  chk_done_once: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  chk_ready_low: assert property (take |=> !cmd_ready_o)
    else $error("ready high after take");
  chk_mem_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
    && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o))
    else $error("memory request changed before ack");
  chk_pair_step: assert property (
    mem_req_o && mem_ack_i ##1 mem_req_o |->
    mem_addr_o == $past(mem_addr_o) + 20'h00002 ||
    mem_addr_o == $past(mem_addr_o) - 20'h00002)
    else $error("second word not two bytes away");
  chk_reg_done: assert property (
    take && cmd_smode_i inside {AWX_SM_REG, AWX_SM_IMM} &&
    !(cmd_op_i inside {AWX_OP_CALL, AWX_OP_RET}) && cmd_dmode_i == AWX_DM_REG
    |=> !mem_req_o ##1 done_o && !mem_req_o)
    else $error("register op timing wrong");
  chk_ret_read: assert property (
    take && cmd_op_i == AWX_OP_RET |-> ##[1:3] mem_req_o && !mem_we_o)
    else $error("return did not read stack");
  chk_call_push: assert property (
    take && cmd_op_i == AWX_OP_CALL |-> ##[1:60]
    mem_req_o && mem_we_o && mem_wdata_o[15:4] == 12'h000)
    else $error("call pushed no high word");

  cov_call: cover property (take && cmd_op_i == AWX_OP_CALL);
  cov_ret: cover property (take && cmd_op_i == AWX_OP_RET);
  cov_stall: cover property (mem_req_o && !mem_ack_i [*2]);
endmodule // awx_exec_props

bind awx_exec awx_exec_props u_props (.*);

// ==== tb/awx_exec_tb.sv ====
module awx_exec_tb
  import awx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cmd_valid_i = 1'b0;
  logic cmd_ready_o, done_o, mem_req_o, mem_we_o, mem_ack_i, wb_ack_o;
  awx_op_t cmd_op_i = AWX_OP_CLR;
  awx_smode_t cmd_smode_i = AWX_SM_REG;
  awx_dmode_t cmd_dmode_i = AWX_DM_REG;
  logic [3:0] cmd_src_i = 4'h0, cmd_dst_i = 4'h0, wb_sel_i = 4'hF;
  logic [19:0] cmd_imm_i = 20'h00000, mem_addr_o;
  logic [15:0] mem_wdata_o, mem_rdata_i;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, slow = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  int error_cnt = 0, comparisons = 0;
  logic [19:0] vd [5] = '{20'h00005, 20'h00003, 20'h7FFFF, 20'h80000,
    20'h12345};
  logic [19:0] vs [5] = '{20'h00003, 20'h00005, 20'hFFFFF, 20'h00001,
    20'h12345};
  logic [19:0] vi [8] = '{20'hFFFFE, 20'hFFFFF, 20'h7FFFE, 20'h7FFFF,
    20'h00000, 20'h00001, 20'h00002, 20'h80000};

  always #12.5 clk_i = ~clk_i;
  awx_exec uut (.*);
  awx_mem_model u_mem (.clk_i, .rst_i, .slow_i(slow), .req_i(mem_req_o),
    .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
      error_cnt++;
  endtask

  task automatic wr(input logic [3:0] r, input logic [19:0] v);
    wb(1'b1, {2'b00, r, 2'b00}, {12'h000, v});
  endtask

  task automatic rd(input logic [3:0] r, input logic [19:0] v);
    wb(1'b0, {2'b00, r, 2'b00}, 32'h0);
    chk(q, {12'h000, v});
  endtask

  // expected flags packed as v n z c
  task automatic fl(input logic [3:0] f);
    wb(1'b0, 8'h40, 32'h0);
    chk({28'h0, q[12], q[6:4]}, {28'h0, f});
  endtask

  task automatic cmd(input awx_op_t op, input awx_smode_t sm,
    input logic [3:0] s, input logic [3:0] d, input logic [19:0] imm);
    int n;
    n = 0;
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_op_i <= op;
    cmd_smode_i <= sm;
    cmd_src_i <= s;
    cmd_dst_i <= d;
    cmd_imm_i <= imm;
    do
      @(posedge clk_i);
    while (cmd_ready_o !== 1'b1);
    cmd_valid_i <= 1'b0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (done_o !== 1'b1 && n < 100);
    if (done_o !== 1'b1)
      error_cnt++;
  endtask

  function automatic logic [23:0] sub20(input logic [19:0] d,
    input logic [19:0] s);
    logic [20:0] t;
    t = {1'b0, d} + {1'b0, ~s} + 21'h000001;
    return {s[19] != d[19] && t[19] != d[19], t[19], t[19:0] == 20'h0,
      t[20], t[19:0]};
  endfunction

  function automatic logic [23:0] add20(input logic [19:0] d,
    input logic [19:0] s);
    logic [20:0] t;
    t = {1'b0, d} + {1'b0, s};
    return {s[19] == d[19] && t[19] != d[19], t[19], t[19:0] == 20'h0,
      t[20], t[19:0]};
  endfunction

  // under a thousand cycles expected; the 16000-cycle cut off lies far beyond that
  initial
  begin
    #400us;
    error_cnt++;
    complete_run();
  end

  initial
  begin
    logic [23:0] e;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h5, 20'h00000);
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    rd(4'h2, 20'h00000);
    wb(1'b0, 8'h7C, 32'h0);
    chk(q, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 5; i++)
    begin
      wr(4'h4, vd[i]);
      wr(4'h5, vs[i]);
      e = sub20(vd[i], vs[i]);
      cmd(AWX_OP_CMP, AWX_SM_IMM, 4'h0, 4'h4, vs[i]);
      rd(4'h4, vd[i]);
      fl(e[23:20]);
      cmd(AWX_OP_SUB, AWX_SM_REG, 4'h5, 4'h4, 20'h00000);
      rd(4'h4, e[19:0]);
      rd(4'h5, vs[i]);
    end
    $display("test compare subtract done");
    wr(4'h2, 20'hFFFFF);
    for (int i = 0; i < 8; i++)
    begin
      wr(4'h7, vi[i]);
      cmd(AWX_OP_TST, AWX_SM_IMM, 4'h0, 4'h7, 20'h00000);
      e = sub20(vi[i], 20'h00000);
      rd(4'h7, vi[i]);
      fl(e[23:20]);
      cmd(AWX_OP_INCD, AWX_SM_IMM, 4'h0, 4'h7, 20'h00002);
      e = add20(vi[i], 20'h00002);
      rd(4'h7, e[19:0]);
      fl(e[23:20]);
      wr(4'h7, vi[i]);
      cmd(AWX_OP_DECD, AWX_SM_IMM, 4'h0, 4'h7, 20'h00002);
      e = sub20(vi[i], 20'h00002);
      rd(4'h7, e[19:0]);
      fl(e[23:20]);
      cmd(AWX_OP_MOV, AWX_SM_REG, 4'h7, 4'h8, 20'h00000);
      rd(4'h8, e[19:0]);
      cmd(AWX_OP_CLR, AWX_SM_IMM, 4'h0, 4'h8, 20'h00000);
      rd(4'h8, 20'h00000);
      fl(e[23:20]);
    end
    wb(1'b0, 8'h08, 32'h0);
    chk(q & 32'hFFFFFEF8, 32'h000FFEF8);
    $display("test unary done");
    // memory is filled through the block itself, the model owns its array
    wr(4'h8, 20'h5BEEF);
    cmd_dmode_i <= AWX_DM_ABS;
    cmd(AWX_OP_MOV, AWX_SM_REG, 4'h8, 4'h0, 20'h00100);
    wr(4'h8, 20'hA1234);
    cmd(AWX_OP_MOV, AWX_SM_REG, 4'h8, 4'h0, 20'h00200);
    cmd_dmode_i <= AWX_DM_REG;
    chk({16'h0, u_mem.mem_q[11'h080]}, 32'h0000BEEF);
    chk({16'h0, u_mem.mem_q[11'h081]}, 32'h00000005);
    chk({16'h0, u_mem.mem_q[11'h100]}, 32'h00001234);
    chk({16'h0, u_mem.mem_q[11'h101]}, 32'h0000000A);
    wr(4'h8, 20'h00000);
    wr(4'h9, 20'h00100);
    cmd(AWX_OP_MOV, AWX_SM_INDINC, 4'h9, 4'h8, 20'h00000);
    rd(4'h8, 20'h5BEEF);
    rd(4'h9, 20'h00104);
    cmd_dmode_i <= AWX_DM_IDX;
    cmd(AWX_OP_MOV, AWX_SM_REG, 4'h8, 4'h9, 20'h0FFF0);
    cmd_dmode_i <= AWX_DM_REG;
    chk({16'h0, u_mem.mem_q[11'h07A]}, 32'h0000BEEF);
    chk({16'h0, u_mem.mem_q[11'h07B]}, 32'h00000005);
    $display("test move memory done");
    slow <= 1'b0;
    wr(4'h5, 20'h001F0);
    wr(4'h1, 20'h00300);
    wr(4'h0, 20'h45678);
    wr(4'h6, 20'h00200);
    wr(4'h2, 20'h00ABC);
    cmd(AWX_OP_CALL, AWX_SM_IDX, 4'h5, 4'h0, 20'h00010);
    rd(4'h0, 20'hA1234);
    rd(4'h1, 20'h002FC);
    chk({16'h0, u_mem.mem_q[11'h17F]}, 32'h00000004);
    chk({16'h0, u_mem.mem_q[11'h17E]}, 32'h00005678);
    cmd(AWX_OP_CALL, AWX_SM_INDINC, 4'h6, 4'h0, 20'h00000);
    rd(4'h6, 20'h00204);
    rd(4'h1, 20'h002F8);
    cmd(AWX_OP_RET, AWX_SM_REG, 4'h0, 4'h0, 20'h00000);
    rd(4'h0, 20'hA1234);
    cmd(AWX_OP_RET, AWX_SM_REG, 4'h0, 4'h0, 20'h00000);
    rd(4'h0, 20'h45678);
    rd(4'h1, 20'h00300);
    rd(4'h2, 20'h00ABC);
    $display("test call return done");
    // enable low: an offered clear must not be taken
    ce_i <= 1'b0;
    cmd_valid_i <= 1'b1;
    cmd_op_i <= AWX_OP_CLR;
    cmd_dst_i <= 4'h2;
    repeat (4) @(posedge clk_i);
    chk({31'h0, done_o}, 32'h0);
    cmd_valid_i <= 1'b0;
    ce_i <= 1'b1;
    rd(4'h2, 20'h00ABC);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h1, 20'h00000);
    rd(4'h0, 20'h00000);
    $display("test freeze reset done");
    complete_run();
  end
endmodule // awx_exec_tb

// ==== tb/awx_mem_model.sv ====
module awx_mem_model
(
  // control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  // word port
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [19:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  output logic ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem_q [2048];
  logic [1:0] wait_q;

  // idle read bus toggles so a stale word never passes for data
  always_ff @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (rst_i)
    begin
      wait_q <= 2'h0;
      rdata_o <= 16'h0000;
    end
    else if (req_i && !ack_o)
    begin
      wait_q <= wait_q + 2'h1;
      if (!slow_i || wait_q == 2'h3)
      begin
        ack_o <= 1'b1;
        wait_q <= 2'h0;
        if (we_i)
          mem_q[addr_i[11:1]] <= wdata_i;
        else
          rdata_o <= mem_q[addr_i[11:1]];
      end
    end
  end
endmodule // awx_mem_model
